/* File: logic/lep_divider.sv */
// Sequential restoring divider used to scale the raw position.
`timescale 1ns/10ps
module lep_divider (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        start,
    input  wire logic [16:0] dividend,
    input  wire logic [6:0]  divisor,
    output logic             done,
    output logic [16:0]      quotient
);

    typedef struct packed {
        logic        busy;
        logic [4:0]  cnt;
        logic [7:0]  rem;
        logic [6:0]  dvs;
        logic [16:0] quo;
        logic        done;
    } lep_div_state_type;

    lep_div_state_type s_q;
    lep_div_state_type s_d;
    logic [7:0]        trial;

    always_comb begin
        s_d = s_q;
        trial = {s_q.rem[6:0], s_q.quo[16]};
        s_d.done = 1'b0;
        if (start && !s_q.busy) begin
            s_d.busy = 1'b1;
            s_d.cnt = 5'h11;
            s_d.rem = 8'h00;
            s_d.dvs = divisor;
            s_d.quo = dividend;
        end else if (s_q.busy) begin
            if (trial >= {1'b0, s_q.dvs}) begin
                s_d.rem = trial - {1'b0, s_q.dvs};
                s_d.quo = {s_q.quo[15:0], 1'b1};
            end else begin
                s_d.rem = trial;
                s_d.quo = {s_q.quo[15:0], 1'b0};
            end
            s_d.cnt = s_q.cnt - 5'h01;
            if (s_q.cnt == 5'h01) begin
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign done     = s_q.done;
    assign quotient = s_q.quo;

endmodule

/* File: logic/lep_param_regs.sv */
// Holding-register parameter bank of the absolute linear position encoder.
//
// Contract
// - scaling bit selects default or programmed resolution
// - default resolution 0.1 mm, 14-bit count
// - direction bit reverses counting direction
// - below zero wraps to all ones of width
// - node address defaults 1, valid 1 to 247
// - address 0 is broadcast, 248-255 reserved
// - written node address 0 becomes 1
// - written node address above 247 becomes 1
// - rate selector picks rate and parity
// - rate selector resets to 4, holds 0-8
// - control bit 8 enables the watchdog
// - one second silence raises watchdog alarm
// - pending alarm shows when communication resumes
// - rising control bit 9 saves parameters
// - rising control bit 10 restores factory defaults
// - rising control bit 11 performs homing
// - homing captures current position into offset
// - offset kept only after a save
// - position equals read plus preset minus offset
// - status low byte mirrors option low byte
// - watchdog alarm clears once communication restored; here it clears on the second message after the outage
`timescale 1ns/10ps
module lep_param_regs #(
    parameter logic [31:0] WD_CYCLES = lep_pkg::LEP_WD_CYCLES
) (
    input  wire logic        clock,
    input  wire logic        rstn,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    input  wire logic        reg_input,
    input  wire logic [15:0] reg_addr,
    input  wire logic [15:0] reg_wdata,
    input  wire logic        msg_seen,
    input  wire logic [13:0] raw_pos,
    output logic             reg_ack,
    output logic             reg_err,
    output logic [15:0]      reg_rdata,
    output logic [7:0]       node_addr,
    output logic [1:0]       rate_code,
    output logic [1:0]       parity_code,
    output logic [13:0]      position,
    output logic             wd_alarm,
    output logic             nv_save,
    output logic [15:0]      param_res,
    output logic [15:0]      param_preset,
    output logic [15:0]      param_offset,
    output logic [15:0]      param_opts
);

    // ==========================================================
    // State
    typedef struct packed {
        logic [15:0]            res;
        logic [15:0]            preset;
        logic [15:0]            offset;
        logic [15:0]            opts;
        logic [15:0]            node;
        logic [15:0]            rate;
        logic [15:0]            ctrl;
        logic [2:0]             prev_cmd;
        logic [13:0]            read_pos;
        logic [13:0]            position;
        lep_pkg::lep_phase_type phase;
        logic                   div_start;
        logic                   wd_alarm;
        logic                   wd_shown;
        logic                   nv_save;
        logic                   ack;
        logic                   err;
        logic [15:0]            rdata;
        logic [1:0]             rate_code;
        logic [1:0]             parity_code;
    } lep_state_type;

    lep_state_type s_q;
    lep_state_type s_d;
    logic          div_done;
    logic [16:0]   div_quo;
    logic          wd_timeout;
    logic [2:0]    cmd_rise;
    logic [13:0]   cur_mask;
    logic [13:0]   scaled;

    // ==========================================================
    // Functions
    // Mask of the current count width: smallest N with res * 2^N covering the length.
    function automatic logic [13:0] pos_mask(input logic [15:0] res, input logic scale);
        logic [3:0]  bits;
        logic [22:0] span;
        bits = lep_pkg::LEP_DEFAULT_BITS;
        span = 23'h0;
        if (scale) begin
            for (int n = 14; n >= 1; n--) begin
                span = 23'({7'h00, res} << n);
                if (span >= {6'h00, lep_pkg::LEP_LENGTH_HUND}) begin
                    bits = 4'(n);
                end
            end
        end
        pos_mask = 14'(16'hffff >> (5'h10 - {1'b0, bits}));
    endfunction

    // Out-of-range node addresses fall back to the default address.
    function automatic logic [15:0] fix_node(input logic [15:0] value);
        if (value == 16'h0000 || value > lep_pkg::LEP_NODE_MAX) begin
            fix_node = lep_pkg::LEP_NODE_DEFAULT;
        end else begin
            fix_node = value;
        end
    endfunction

    assign cur_mask = pos_mask(s_q.res, s_q.opts[lep_pkg::LEP_OPT_SCALE]);
    assign cmd_rise = s_q.ctrl[lep_pkg::LEP_CTL_HOME:lep_pkg::LEP_CTL_SAVE] & ~s_q.prev_cmd;
    assign scaled   = div_quo[13:0] & cur_mask;

    // ==========================================================
    // Submodules
    lep_divider u_div (
        .clock    (clock),
        .rstn     (rstn),
        .start    (s_q.div_start),
        .dividend (17'({3'h0, raw_pos} * lep_pkg::LEP_RAW_SCALE)),
        .divisor  (s_q.opts[lep_pkg::LEP_OPT_SCALE] ? s_q.res[6:0] :
                   lep_pkg::LEP_RES_DEFAULT[6:0]),
        .done     (div_done),
        .quotient (div_quo)
    );

    lep_watchdog #(
        .WD_CYCLES (WD_CYCLES)
    ) u_wd (
        .clock   (clock),
        .rstn    (rstn),
        .enable  (s_q.ctrl[lep_pkg::LEP_CTL_WD]),
        .kick    (msg_seen),
        .timeout (wd_timeout)
    );

    // ==========================================================
    // Next state
    always_comb begin
        s_d = s_q;
        s_d.ack = 1'b0;
        s_d.err = 1'b0;
        s_d.nv_save = 1'b0;
        s_d.div_start = 1'b0;
        s_d.prev_cmd = s_q.ctrl[lep_pkg::LEP_CTL_HOME:lep_pkg::LEP_CTL_SAVE];

        // Register writes; rejected values leave the register as it was.
        if (reg_wr) begin
            s_d.ack = 1'b1;
            if (reg_input) begin
                s_d.err = 1'b1;
            end else begin
                case (reg_addr)
                    lep_pkg::LEP_HR_RESOLUTION: begin
                        if (reg_wdata >= lep_pkg::LEP_RES_MIN && reg_wdata <= lep_pkg::LEP_RES_MAX) begin
                            s_d.res = reg_wdata;
                        end else begin
                            s_d.err = 1'b1;
                        end
                    end
                    lep_pkg::LEP_HR_PRESET: begin
                        if (reg_wdata <= {2'h0, cur_mask}) begin
                            s_d.preset = reg_wdata;
                        end else begin
                            s_d.err = 1'b1;
                        end
                    end
                    lep_pkg::LEP_HR_OPTIONS: s_d.opts = reg_wdata & lep_pkg::LEP_OPTS_MASK;
                    lep_pkg::LEP_HR_NODE:    s_d.node = fix_node(reg_wdata);
                    lep_pkg::LEP_HR_RATE: begin
                        if (reg_wdata <= lep_pkg::LEP_RATE_MAX) begin
                            s_d.rate = reg_wdata;
                        end else begin
                            s_d.err = 1'b1;
                        end
                    end
                    lep_pkg::LEP_HR_CONTROL: s_d.ctrl = reg_wdata & lep_pkg::LEP_CTRL_MASK;
                    default: s_d.err = 1'b1;
                endcase
            end
        end

        // Register reads answer one cycle after the request.
        if (reg_rd) begin
            s_d.ack = 1'b1;
            s_d.rdata = 16'h0000;
            if (reg_input) begin
                case (reg_addr)
                    lep_pkg::LEP_IR_ALARMS: begin
                        s_d.rdata[lep_pkg::LEP_ALM_WD] = s_q.wd_alarm;
                    end
                    lep_pkg::LEP_IR_POSITION: s_d.rdata = {2'h0, s_q.position};
                    lep_pkg::LEP_IR_STATUS: begin
                        s_d.rdata[7:0] = s_q.opts[7:0];
                        s_d.rdata[lep_pkg::LEP_STS_ALARM] = s_q.wd_alarm;
                    end
                    default: s_d.err = 1'b1;
                endcase
            end else begin
                case (reg_addr)
                    lep_pkg::LEP_HR_RESOLUTION: s_d.rdata = s_q.res;
                    lep_pkg::LEP_HR_PRESET:     s_d.rdata = s_q.preset;
                    lep_pkg::LEP_HR_OFFSET:     s_d.rdata = s_q.offset;
                    lep_pkg::LEP_HR_OPTIONS:    s_d.rdata = s_q.opts;
                    lep_pkg::LEP_HR_NODE:       s_d.rdata = s_q.node;
                    lep_pkg::LEP_HR_RATE:       s_d.rdata = s_q.rate;
                    lep_pkg::LEP_HR_CONTROL:    s_d.rdata = s_q.ctrl;
                    default: s_d.err = 1'b1;
                endcase
            end
        end

        // Rate and parity decode of the selector.
        s_d.rate_code = 2'(s_q.rate / lep_pkg::LEP_RATE_GROUP);
        s_d.parity_code = 2'(s_q.rate % lep_pkg::LEP_RATE_GROUP);

        // Position scaling runs continuously, one division per update.
        case (s_q.phase)
            lep_pkg::LEP_SCALE_IDLE: begin
                s_d.div_start = 1'b1;
                s_d.phase = lep_pkg::LEP_SCALE_BUSY;
            end
            lep_pkg::LEP_SCALE_BUSY: begin
                if (div_done) begin
                    if (s_q.opts[lep_pkg::LEP_OPT_DIR]) begin
                        s_d.read_pos = (cur_mask - scaled) & cur_mask;
                    end else begin
                        s_d.read_pos = scaled;
                    end
                    s_d.position = (s_q.read_pos + s_q.preset[13:0] - s_q.offset[13:0]) & cur_mask;
                    s_d.phase = lep_pkg::LEP_SCALE_IDLE;
                end
            end
            default: s_d.phase = lep_pkg::LEP_SCALE_IDLE;
        endcase

        // Watchdog alarm stays up through the first message after the outage so that
        // the master can see it, and is dropped by the next one. A timeout wins.
        if (msg_seen && s_q.wd_alarm) begin
            if (s_q.wd_shown) begin
                s_d.wd_alarm = 1'b0;
                s_d.wd_shown = 1'b0;
            end else begin
                s_d.wd_shown = 1'b1;
            end
        end
        if (wd_timeout) begin
            s_d.wd_alarm = 1'b1;
            s_d.wd_shown = 1'b0;
        end

        // Edge-triggered commands taken from the stored control word.
        if (cmd_rise[0]) begin
            s_d.nv_save = 1'b1;
        end
        if (cmd_rise[2]) begin
            s_d.offset = {2'h0, s_q.read_pos};
            s_d.position = s_q.preset[13:0] & cur_mask;
        end
        if (cmd_rise[1]) begin
            s_d.res = lep_pkg::LEP_RES_DEFAULT;
            s_d.preset = 16'h0000;
            s_d.offset = 16'h0000;
            s_d.opts = 16'h0000;
            s_d.node = lep_pkg::LEP_NODE_DEFAULT;
            s_d.rate = lep_pkg::LEP_RATE_DEFAULT;
        end
    end

    // ==========================================================
    // Registers
    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
            s_q.res <= lep_pkg::LEP_RES_DEFAULT;
            s_q.node <= lep_pkg::LEP_NODE_DEFAULT;
            s_q.rate <= lep_pkg::LEP_RATE_DEFAULT;
            s_q.rate_code <= 2'h1;
            s_q.parity_code <= 2'h1;
            s_q.phase <= lep_pkg::LEP_SCALE_IDLE;
        end else begin
            s_q <= s_d;
        end
    end

    assign reg_ack      = s_q.ack;
    assign reg_err      = s_q.err;
    assign reg_rdata    = s_q.rdata;
    assign node_addr    = s_q.node[7:0];
    assign rate_code    = s_q.rate_code;
    assign parity_code  = s_q.parity_code;
    assign position     = s_q.position;
    assign wd_alarm     = s_q.wd_alarm;
    assign nv_save      = s_q.nv_save;
    assign param_res    = s_q.res;
    assign param_preset = s_q.preset;
    assign param_offset = s_q.offset;
    assign param_opts   = s_q.opts;

    // ==========================================================
    // Assertions
    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_node_zero;
        reg_wr && !reg_input && reg_addr == lep_pkg::LEP_HR_NODE && reg_wdata == 16'h0000
            && !cmd_rise[1] |=> node_addr == 8'h01;
    endproperty
    a_node_zero: assert property (p_node_zero)
        else $error("node address zero not replaced by one");

    property p_node_high;
        reg_wr && !reg_input && reg_addr == lep_pkg::LEP_HR_NODE && reg_wdata > 16'h00f7
            |=> node_addr == 8'h01;
    endproperty
    a_node_high: assert property (p_node_high)
        else $error("node address above limit not replaced by one");

    property p_node_range;
        s_q.node >= 16'h0001 && s_q.node <= 16'h00f7;
    endproperty
    a_node_range: assert property (p_node_range)
        else $error("node address out of range");

    property p_rate_range;
        s_q.rate <= 16'h0008 ##1 rate_code == 2'($past(s_q.rate) / 16'h0003);
    endproperty
    a_rate_range: assert property (p_rate_range)
        else $error("rate selector out of range or badly decoded");

    property p_save_edge;
        $rose(s_q.ctrl[9]) |-> ##1 nv_save ##1 !nv_save;
    endproperty
    a_save_edge: assert property (p_save_edge)
        else $error("save pulse missing or too long");

    property p_save_level;
        s_q.ctrl[9] && $past(s_q.ctrl[9]) |=> !nv_save;
    endproperty
    a_save_level: assert property (p_save_level)
        else $error("save repeated while command bit held");

    property p_load;
        $rose(s_q.ctrl[10]) |=> param_res == 16'h000a && node_addr == 8'h01
            && param_offset == 16'h0000;
    endproperty
    a_load: assert property (p_load)
        else $error("defaults not restored");

    property p_home;
        $rose(s_q.ctrl[11]) && !s_q.ctrl[10] |=> param_offset == {2'h0, $past(s_q.read_pos)};
    endproperty
    a_home: assert property (p_home)
        else $error("homing did not capture the position");

    property p_status;
        reg_rd && reg_input && reg_addr == lep_pkg::LEP_IR_STATUS |=>
            reg_ack && reg_rdata[7:0] == $past(s_q.opts[7:0]);
    endproperty
    a_status: assert property (p_status)
        else $error("status low byte differs from options");

    property p_wd_raise;
        wd_timeout |=> wd_alarm [*2];
    endproperty
    a_wd_raise: assert property (p_wd_raise)
        else $error("watchdog alarm not raised and held");

    property p_pos_wrap;
        div_done |=> (position & ~$past(cur_mask)) == 14'h0000;
    endproperty
    a_pos_wrap: assert property (p_pos_wrap)
        else $error("position outside current count width");

endmodule

/* File: logic/lep_pkg.sv */
// Shared constants and types of the linear encoder parameter register bank.
package lep_pkg;

    // ==========================================================
    // Clock and timing
    localparam int unsigned LEP_CLK_HZ      = 100_000_000;
    localparam int unsigned LEP_WD_TIME_MS  = 1000;
    localparam logic [31:0] LEP_WD_CYCLES   = 32'(LEP_CLK_HZ / 1000 * LEP_WD_TIME_MS);

    // ==========================================================
    // Holding register offsets
    localparam logic [15:0] LEP_HR_RESOLUTION = 16'h0000;
    localparam logic [15:0] LEP_HR_PRESET     = 16'h0001;
    localparam logic [15:0] LEP_HR_OFFSET     = 16'h0002;
    localparam logic [15:0] LEP_HR_OPTIONS    = 16'h0003;
    localparam logic [15:0] LEP_HR_NODE       = 16'h0004;
    localparam logic [15:0] LEP_HR_RATE       = 16'h0005;
    localparam logic [15:0] LEP_HR_CONTROL    = 16'h000a;

    // ==========================================================
    // Input register offsets
    localparam logic [15:0] LEP_IR_ALARMS     = 16'h0000;
    localparam logic [15:0] LEP_IR_POSITION   = 16'h0001;
    localparam logic [15:0] LEP_IR_STATUS     = 16'h0006;

    // ==========================================================
    // Field positions and masks
    localparam int          LEP_OPT_SCALE     = 0;
    localparam int          LEP_OPT_DIR       = 1;
    localparam int          LEP_CTL_WD        = 8;
    localparam int          LEP_CTL_SAVE      = 9;
    localparam int          LEP_CTL_LOAD      = 10;
    localparam int          LEP_CTL_HOME      = 11;
    localparam int          LEP_ALM_WD        = 11;
    localparam int          LEP_STS_ALARM     = 8;
    localparam logic [15:0] LEP_OPTS_MASK     = 16'h0003;
    localparam logic [15:0] LEP_CTRL_MASK     = 16'h0f00;

    // ==========================================================
    // Reset values and limits
    localparam logic [15:0] LEP_RES_DEFAULT   = 16'h000a;
    localparam logic [15:0] LEP_RES_MIN       = 16'h000a;
    localparam logic [15:0] LEP_RES_MAX       = 16'h007d;
    localparam logic [15:0] LEP_NODE_DEFAULT  = 16'h0001;
    localparam logic [15:0] LEP_NODE_MAX      = 16'h00f7;
    localparam logic [15:0] LEP_RATE_DEFAULT  = 16'h0004;
    localparam logic [15:0] LEP_RATE_MAX      = 16'h0008;
    localparam logic [15:0] LEP_RATE_GROUP    = 16'h0003;
    localparam logic [16:0] LEP_LENGTH_HUND   = 17'h1e848;
    localparam logic [3:0]  LEP_DEFAULT_BITS  = 4'he;
    localparam logic [16:0] LEP_RAW_SCALE     = 17'h0000a;

    typedef enum logic [0:0] {LEP_SCALE_IDLE, LEP_SCALE_BUSY} lep_phase_type;

endpackage

/* File: logic/lep_watchdog.sv */
// Communication watchdog timer that pulses once when no message arrives in time.
`timescale 1ns/10ps
module lep_watchdog #(
    parameter logic [31:0] WD_CYCLES = lep_pkg::LEP_WD_CYCLES
) (
    input  wire logic clock,
    input  wire logic rstn,
    input  wire logic enable,
    input  wire logic kick,
    output logic      timeout
);

    typedef struct packed {
        logic [31:0] cnt;
        logic        fired;
        logic        timeout;
    } lep_wd_state_type;

    lep_wd_state_type s_q;
    lep_wd_state_type s_d;

    always_comb begin
        s_d = s_q;
        s_d.timeout = 1'b0;
        if (!enable || kick) begin
            s_d.cnt = 32'h0000_0000;
            s_d.fired = 1'b0;
        end else if (!s_q.fired) begin
            if (s_q.cnt == WD_CYCLES - 32'h0000_0001) begin
                s_d.fired = 1'b1;
                s_d.timeout = 1'b1;
            end else begin
                s_d.cnt = s_q.cnt + 32'h0000_0001;
            end
        end
    end

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) begin
            s_q <= '0;
        end else begin
            s_q <= s_d;
        end
    end

    assign timeout = s_q.timeout;

    default clocking cb @(posedge clock); endclocking
    default disable iff (!rstn);

    property p_wd_no_early;
        enable && !kick && s_q.cnt < WD_CYCLES - 32'h0000_0001 |=> !timeout;
    endproperty
    a_wd_no_early: assert property (p_wd_no_early)
        else $error("watchdog fired before its time");

endmodule

/* File: verif/lep_master_model.sv */
// Bus master model that issues one register request per received message.
`timescale 1ns/10ps
module lep_master_model (
    input  wire logic        clock,
    output logic             reg_wr,
    output logic             reg_rd,
    output logic             reg_input,
    output logic [15:0]      reg_addr,
    output logic [15:0]      reg_wdata,
    output logic             msg_seen
);
    initial begin
        {reg_wr, reg_rd, reg_input, msg_seen} = 4'h0;
        reg_addr = 16'h0000;
        reg_wdata = 16'h0000;
    end

    // ==========================================================
    // Each request is one message, so it also restarts the watchdog.
    task automatic xfer(input logic w, input logic i, input logic [15:0] a, input logic [15:0] d);
        @(posedge clock);
        #1;
        reg_wr = w;
        reg_rd = ~w;
        reg_input = i;
        reg_addr = a;
        reg_wdata = d;
        msg_seen = 1'b1;
        @(posedge clock);
        #1;
        {reg_wr, reg_rd, msg_seen} = 3'h0;
        reg_input = ~i;
        reg_addr = ~a;
        reg_wdata = ~d;
    endtask
endmodule

/* File: verif/lep_param_regs_tb.sv */
// Self-checking bench of the linear encoder parameter register bank.
`timescale 1ns/10ps
module lep_param_regs_tb;
    logic        clock = 1'b0;
    logic        rstn = 1'b0;
    logic        reg_wr, reg_rd, reg_input, msg_seen, reg_ack, reg_err, wd_alarm, nv_save, e_err;
    logic [15:0] reg_addr, reg_wdata, reg_rdata, param_res, param_offset, param_opts, r, e_v, e_m;
    logic [15:0] param_preset;
    logic [13:0] raw_pos = 14'h0000;
    logic [13:0] position, h;
    logic [7:0]  node_addr;
    logic [1:0]  rate_code, parity_code;
    logic        q_err[$];
    logic [15:0] q_val[$], q_msk[$];
    int          num_errors = 0, num_checks = 0, cycles = 0, nv_cnt = 0;

    always #5 clock = ~clock;

    lep_param_regs #(.WD_CYCLES(32'h0000_0032)) uut (
        .clock(clock), .rstn(rstn), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_input(reg_input),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .msg_seen(msg_seen), .raw_pos(raw_pos),
        .reg_ack(reg_ack), .reg_err(reg_err), .reg_rdata(reg_rdata), .node_addr(node_addr),
        .rate_code(rate_code), .parity_code(parity_code), .position(position),
        .wd_alarm(wd_alarm), .nv_save(nv_save), .param_res(param_res),
        .param_preset(param_preset),
        .param_offset(param_offset), .param_opts(param_opts));

    lep_master_model mst (
        .clock(clock), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_input(reg_input),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .msg_seen(msg_seen));

    // ==========================================================
    // Checking helpers.
    task automatic chk(input logic ok, input string msg);
        num_checks++;
        if (ok !== 1'b1) begin
            num_errors++;
            $display("mismatch at %0t: %s", $time, msg);
        end
    endtask
    task automatic wr(input logic [15:0] a, input logic [15:0] d, input logic e);
        q_err.push_back(e);
        q_val.push_back(16'h0000);
        q_msk.push_back(16'h0000);
        mst.xfer(1'b1, 1'b0, a, d);
    endtask
    task automatic rd(input logic i, input logic [15:0] a, input logic [15:0] v, m);
        q_err.push_back(1'b0);
        q_val.push_back(v);
        q_msk.push_back(m);
        mst.xfer(1'b0, i, a, 16'h0000);
    endtask
    task automatic idle(input int n);
        repeat (n) @(posedge clock);
        #1;
    endtask
    task automatic pos(input logic [13:0] raw, input logic [13:0] exp);
        raw_pos = raw;
        idle(100);
        chk(position === exp, "reported position");
    endtask
    task automatic summarize();
        $display("checks %0d mismatches %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0)
            $display("Run complete: PASS");
        else
            $display("Run complete: FAIL");
        $finish;
    endtask

    // ==========================================================
    // Answer monitor and limits.
    always @(negedge clock) begin
        if (nv_save === 1'b1)
            nv_cnt++;
        if (reg_ack === 1'b1) begin
            if (q_err.size() == 0) begin
                chk(1'b0, "unexpected answer");
            end else begin
                e_err = q_err.pop_front();
                e_v = q_val.pop_front();
                e_m = q_msk.pop_front();
                chk(reg_err === e_err && (reg_rdata & e_m) === (e_v & e_m), "bus answer");
            end
        end
    end
    always @(posedge clock) begin
        cycles++;
        if (cycles > 20000) begin
            num_errors++;
            summarize();
        end
    end

    // ==========================================================
    // Scenarios.
    initial begin
        void'($urandom(32'h4324));
        repeat (2) @(posedge clock);
        #1 rstn = 1'b1;
        rd(1'b0, 16'h0004, 16'h0001, 16'hffff);
        rd(1'b0, 16'h0005, 16'h0004, 16'hffff);
        $display("test reset values finished");
        wr(16'h0004, 16'h0000, 1'b0);
        rd(1'b0, 16'h0004, 16'h0001, 16'hffff);
        wr(16'h0004, 16'h00f8, 1'b0);
        rd(1'b0, 16'h0004, 16'h0001, 16'hffff);
        r = 16'($urandom_range(247, 1));
        wr(16'h0004, r, 1'b0);
        rd(1'b0, 16'h0004, r, 16'hffff);
        idle(2);
        chk(node_addr === r[7:0], "node output");
        $display("test node address finished");
        for (int i = 0; i < 9; i++) begin
            wr(16'h0005, 16'(i), 1'b0);
            idle(2);
            chk(rate_code === 2'(i / 3) && parity_code === 2'(i % 3), "rate code");
        end
        wr(16'h0005, 16'h0009, 1'b1);
        rd(1'b0, 16'h0005, 16'h0008, 16'hffff);
        $display("test rate selector finished");
        wr(16'h0003, 16'h0003, 1'b0);
        rd(1'b1, 16'h0006, 16'h0003, 16'h00ff);
        wr(16'h0003, 16'h0000, 1'b0);
        pos(14'h04d2, 14'h04d2);
        wr(16'h0003, 16'h0002, 1'b0);
        pos(14'h04d2, 14'h3b2d);
        wr(16'h0000, 16'h0019, 1'b0);
        wr(16'h0003, 16'h0001, 1'b0);
        pos(14'h03e8, 14'h0190);
        wr(16'h0003, 16'h0000, 1'b0);
        $display("test scaling and direction finished");
        wr(16'h0001, 16'h0032, 1'b0);
        h = 14'($urandom_range(16000, 200));
        pos(h, h + 14'h0032);
        chk(param_preset === 16'h0032, "preset register");
        wr(16'h000a, 16'h0800, 1'b0);
        idle(100);
        chk(position === 14'h0032 && param_offset === {2'b00, h}, "homing");
        nv_cnt = 0;
        wr(16'h000a, 16'h0a00, 1'b0);
        wr(16'h000a, 16'h0a00, 1'b0);
        idle(4);
        chk(nv_cnt == 1, "save pulses");
        pos(h + 14'h0005, 14'h0037);
        wr(16'h0001, 16'h0000, 1'b0);
        wr(16'h000a, 16'h0000, 1'b0);
        wr(16'h000a, 16'h0800, 1'b0);
        pos(h + 14'h0005, 14'h0000);
        pos(h + 14'h0004, 14'h3fff);
        $display("test homing finished");
        wr(16'h000a, 16'h0000, 1'b0);
        wr(16'h000a, 16'h0400, 1'b0);
        idle(3);
        chk(param_offset === 16'h0000 && node_addr === 8'h01, "load defaults");
        chk(param_res === 16'h000a && param_opts === 16'h0000, "load defaults");
        rd(1'b0, 16'h0005, 16'h0004, 16'hffff);
        wr(16'h0002, 16'h0005, 1'b1);
        wr(16'h0007, 16'h0005, 1'b1);
        $display("test defaults and refusals finished");
        wr(16'h000a, 16'h0100, 1'b0);
        idle(80);
        chk(wd_alarm === 1'b1, "watchdog alarm");
        rd(1'b1, 16'h0000, 16'h0800, 16'h0800);
        rd(1'b1, 16'h0000, 16'h0800, 16'h0800);
        idle(2);
        chk(wd_alarm === 1'b0, "alarm cleared");
        wr(16'h000a, 16'h0000, 1'b0);
        idle(80);
        chk(wd_alarm === 1'b0, "watchdog off");
        $display("test watchdog finished");
        idle(4);
        chk(q_err.size() == 0, "answers missing");
        summarize();
    end
endmodule
